// file: hdl/frm_fault_mgr.sv
// Fault response manager of a dual-channel step-down controller
`timescale 1ns/100ps
`default_nettype none
module frm_fault_mgr
    import frm_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register bus
    input  wire frm_avm_t    avm,
    output var  logic [31:0] avm_readdata,
    output var  logic        avm_waitrequest,
    // Fault sources and telemetry
    input  wire logic [5:0]  fault_class_ch0,
    input  wire logic [5:0]  fault_class_ch1,
    input  wire logic [15:0] meas_ch0,
    input  wire logic [15:0] meas_ch1,
    input  wire logic [1:0]  pwm_top,
    // Die temperature comparators
    input  wire logic        temp_over_85,
    input  wire logic        temp_over_130,
    input  wire logic        temp_below_120,
    // Memory access gate
    input  wire logic        nvm_req,
    output var  logic        nvm_grant,
    // Gate drives
    output var  logic [1:0]  top_gate_drive,
    output var  logic [1:0]  bottom_gate_drive,
    // Open-drain shared lines
    input  wire logic [1:0]  fault_flag_pin_in,
    output var  logic [1:0]  fault_flag_pin_out,
    output var  logic [1:0]  fault_flag_pin_oe_n,
    input  wire logic [1:0]  channel_run_pin_in,
    output var  logic [1:0]  channel_run_pin_out,
    output var  logic [1:0]  channel_run_pin_oe_n,
    input  wire logic        sync_pin_in,
    output var  logic        sync_pin_out,
    output var  logic        sync_pin_oe_n,
    input  wire logic        timebase_pin_in,
    output var  logic        timebase_pin_out,
    output var  logic        timebase_pin_oe_n
);

    frm_state_t       st_r;
    frm_state_t       st_nxt;
    logic [NAS-1:0]   async_in;
    logic [1:0][5:0]  cls;
    logic [1:0][5:0]  fsel;
    logic [1:0][1:0]  resp;
    logic [1:0][15:0] meas;
    logic [1:0]       ext;
    logic [1:0]       run;
    logic             wr_go;
    logic [3:0]       clr;
    logic             tick;
    logic [15:0]      tb_next;
    logic [15:0]      sy_next;

    // Gather the fault, pin and temperature levels for the two-stage synchroniser
    assign async_in = {timebase_pin_in, sync_pin_in, temp_below_120,
                       temp_over_130, temp_over_85, channel_run_pin_in,
                       fault_flag_pin_in, fault_class_ch1,
                       fault_class_ch0};

    // Decoded views of synchronised inputs and settings
    assign cls  = st_r.s2[11:0];
    assign fsel = st_r.flagsel;
    assign resp = {st_r.ctrl[4:3], st_r.ctrl[2:1]};
    assign meas = {meas_ch1, meas_ch0};
    assign run  = st_r.s2[15:14];
    // Own release must settle before a low is taken as foreign
    assign ext[0] = !st_r.s2[AI_FLAG] && (&st_r.ch[0].fhist);
    assign ext[1] = !st_r.s2[AI_FLAG+1] && (&st_r.ch[1].fhist);
    // Write completes on the cycle waitrequest is low
    assign wr_go = avm.write && !st_r.wait_r;
    assign clr   = (wr_go && avm.address == A_CLEAR) ?
                   avm.writedata[3:0] : 4'h0;
    // Retry timing follows falling edges of the shared timebase line
    assign tick  = st_r.tb_d && !st_r.s2[AI_TB];
    assign tb_next = (st_r.tcnt == TB_PER_CYC - 16'h1) ?
                     16'h0 : st_r.tcnt + 16'h1;
    assign sy_next = (st_r.scnt >= st_r.syncper - 16'h1) ?
                     16'h0 : st_r.scnt + 16'h1;

    // Next-state logic for the whole block
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.s1      = async_in;
        st_nxt.s2      = st_r.s1;
        st_nxt.tb_d    = st_r.s2[AI_TB];
        st_nxt.od_zero = 1'b0;
        st_nxt.wait_r  = 1'b1;
        st_nxt.rdata   = 32'h0;

        // Bus slave: answer one cycle after a request appears
        if ((avm.read || avm.write) && st_r.wait_r)
        begin
            st_nxt.wait_r = 1'b0;
            if (avm.read)
            begin
                case (avm.address)
                    A_CTRL:    st_nxt.rdata = {25'h0, st_r.ctrl};
                    A_FLAGSEL: st_nxt.rdata = {20'h0, st_r.flagsel};
                    A_RETRY:   st_nxt.rdata = {16'h0, st_r.retry};
                    A_STATUS:  st_nxt.rdata = {21'h0,
                        st_r.s2[AI_TB], st_r.s2[AI_SYNC],
                        st_r.log_valid, st_r.s2[AI_T85],
                        st_r.nvm_block,
                        st_r.ch[1].st == CH_RUN && run[1],
                        st_r.ch[0].st == CH_RUN && run[0],
                        st_r.ch[1].st == CH_RETRY,
                        st_r.ch[0].st == CH_RETRY,
                        st_r.ch[1].st == CH_LATCH,
                        st_r.ch[0].st == CH_LATCH};
                    A_PEAK0:   st_nxt.rdata = {16'h0, st_r.ch[0].peak};
                    A_PEAK1:   st_nxt.rdata = {16'h0, st_r.ch[1].peak};
                    A_LOG:     st_nxt.rdata = {st_r.log_peak, 8'h0,
                                   st_r.log_ch, st_r.log_cls};
                    A_SYNCPER: st_nxt.rdata = {16'h0, st_r.syncper};
                    default:   st_nxt.rdata = 32'h0;
                endcase
            end
        end

        // Register writes
        if (wr_go)
        begin
            case (avm.address)
                A_CTRL:    st_nxt.ctrl    = avm.writedata[6:0];
                A_FLAGSEL: st_nxt.flagsel = avm.writedata[11:0];
                A_RETRY:   st_nxt.retry   = avm.writedata[15:0];
                A_SYNCPER: st_nxt.syncper = avm.writedata[15:0];
                default:   st_nxt.ctrl    = st_r.ctrl;
            endcase
        end

        // Log flag: a new capture wins over a clear
        if (clr[2])
            st_nxt.log_valid = 1'b0;

        // Per-channel fault handling
        for (int i = 0; i < 2; i++)
        begin
            st_nxt.ch[i].fhist = {st_r.ch[i].fhist[1:0],
                                  st_r.ch[i].flag_oe_n};
            st_nxt.ch[i].flag_oe_n = ~|(cls[i] & fsel[i]);
            // Running peak, restarted by a clear
            if (clr[3] || meas[i] > st_r.ch[i].peak)
                st_nxt.ch[i].peak = meas[i];
            case (st_r.ch[i].st)
                CH_RUN:
                begin
                    if ((|cls[i] || ext[i]) && resp[i] != RSP_IGNORE)
                    begin
                        st_nxt.ch[i].rcnt = 16'h0;
                        st_nxt.ch[i].st = (resp[i] == RSP_RETRY) ?
                                          CH_RETRY : CH_LATCH;
                        if (st_r.ctrl[CT_LOG] && run[i])
                        begin
                            st_nxt.log_valid = 1'b1;
                            st_nxt.log_cls   = {ext[i], cls[i]};
                            st_nxt.log_ch    = 1'(i);
                            st_nxt.log_peak  = st_r.ch[i].peak;
                        end
                    end
                end
                CH_LATCH:
                begin
                    // Only a run-pin low or a clear re-arms
                    if (clr[i] || !run[i])
                        st_nxt.ch[i].st = CH_RUN;
                end
                CH_RETRY:
                begin
                    if (st_r.ch[i].rcnt >= st_r.retry)
                        st_nxt.ch[i].st = CH_RUN;
                    else if (tick)
                        st_nxt.ch[i].rcnt = st_r.ch[i].rcnt + 16'h1;
                end
                default:
                    st_nxt.ch[i].st = CH_RUN;
            endcase
            // Hold partners down while waiting to retry
            st_nxt.ch[i].run_oe_n = st_nxt.ch[i].st != CH_RETRY;
            // Overvoltage overrides every response
            st_nxt.ch[i].top = pwm_top[i] && !cls[i][FC_OV] &&
                st_nxt.ch[i].st == CH_RUN && run[i];
            st_nxt.ch[i].bot = cls[i][FC_OV] || (!pwm_top[i] &&
                st_nxt.ch[i].st == CH_RUN && run[i]);
        end

        // Sync line: one low pulse per switching period
        if (st_r.ctrl[CT_SYNC])
        begin
            st_nxt.scnt      = sy_next;
            st_nxt.sync_oe_n = !(sy_next < SYNC_LOW_CYC);
        end
        else
        begin
            // Park at period end so enabling starts a full pulse
            st_nxt.scnt      = st_r.syncper - 16'h1;
            st_nxt.sync_oe_n = 1'b1;
        end

        // Shared timebase line
        if (st_r.ctrl[CT_TB])
        begin
            st_nxt.tcnt    = tb_next;
            st_nxt.tb_oe_n = !(tb_next < TB_LOW_CYC);
        end
        else
        begin
            st_nxt.tcnt    = TB_PER_CYC - 16'h1;
            st_nxt.tb_oe_n = 1'b1;
        end

        // Memory access block with hysteresis
        if (st_r.s2[AI_T130])
            st_nxt.nvm_block = 1'b1;
        else if (st_r.s2[AI_T120])
            st_nxt.nvm_block = 1'b0;
        st_nxt.nvm_grant = nvm_req && !st_nxt.nvm_block;
    end

    // State register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_r         <= '0;
            st_r.s1      <= SYNC_IDLE; // No false fault after reset
            st_r.s2      <= SYNC_IDLE;
            st_r.tb_d    <= 1'b1;
            st_r.ctrl    <= CTRL_RST;
            st_r.flagsel <= FSEL_RST;
            st_r.retry   <= RETRY_RST;
            st_r.syncper <= SPER_RST;
            st_r.ch[0].st        <= CH_RUN;
            st_r.ch[1].st        <= CH_RUN;
            st_r.ch[0].flag_oe_n <= 1'b1;
            st_r.ch[1].flag_oe_n <= 1'b1;
            st_r.ch[0].fhist     <= 3'h7;
            st_r.ch[1].fhist     <= 3'h7;
            st_r.ch[0].run_oe_n  <= 1'b1;
            st_r.ch[1].run_oe_n  <= 1'b1;
            st_r.sync_oe_n <= 1'b1;
            st_r.tb_oe_n   <= 1'b1;
            st_r.scnt      <= SPER_RST - 16'h1; // First pulse full
            st_r.tcnt      <= TB_PER_CYC - 16'h1;
            st_r.wait_r    <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs straight from the state register
    assign avm_readdata         = st_r.rdata;
    assign avm_waitrequest      = st_r.wait_r;
    assign nvm_grant            = st_r.nvm_grant;
    assign top_gate_drive       = {st_r.ch[1].top, st_r.ch[0].top};
    assign bottom_gate_drive    = {st_r.ch[1].bot, st_r.ch[0].bot};
    assign fault_flag_pin_out   = {2{st_r.od_zero}};
    assign fault_flag_pin_oe_n  = {st_r.ch[1].flag_oe_n,
                                   st_r.ch[0].flag_oe_n};
    assign channel_run_pin_out  = {2{st_r.od_zero}};
    assign channel_run_pin_oe_n = {st_r.ch[1].run_oe_n,
                                   st_r.ch[0].run_oe_n};
    assign sync_pin_out         = st_r.od_zero;
    assign sync_pin_oe_n        = st_r.sync_oe_n;
    assign timebase_pin_out     = st_r.od_zero;
    assign timebase_pin_oe_n    = st_r.tb_oe_n;

    // Checks
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_sync_pulse;
        ##62 !sync_pin_oe_n ##1 sync_pin_oe_n;
    endsequence
    sequence s_tb_pulse;
        ##124 !timebase_pin_oe_n ##1 timebase_pin_oe_n;
    endsequence

    property p_flag_sel;
        |(cls[0] & fsel[0]) |=> !fault_flag_pin_oe_n[0];
    endproperty
    a_flag_sel: assert property (p_flag_sel)
        else $error("flag pin not pulled for selected fault");
    property p_ext_fault;
        ext[0] && resp[0] == 2'h1 && st_r.ch[0].st == CH_RUN
        |=> st_r.ch[0].st == CH_LATCH;
    endproperty
    a_ext_fault: assert property (p_ext_fault)
        else $error("outside fault not latched");
    property p_ignore;
        resp[0] == RSP_IGNORE && st_r.ch[0].st == CH_RUN
        |=> st_r.ch[0].st == CH_RUN;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("ignored fault changed channel state");
    property p_retry;
        st_r.ch[0].st == CH_RETRY && st_r.ch[0].rcnt >= st_r.retry
        |=> st_r.ch[0].st == CH_RUN;
    endproperty
    a_retry: assert property (p_retry)
        else $error("retry did not restart");
    property p_ov;
        cls[0][FC_OV] |=> !top_gate_drive[0] && bottom_gate_drive[0];
    endproperty
    a_ov: assert property (p_ov)
        else $error("overvoltage did not force gates");
    property p_log;
        st_r.ch[0].st == CH_RUN && st_nxt.ch[0].st != CH_RUN &&
        st_r.ctrl[CT_LOG] && run[0] &&
        st_nxt.ch[1].st == st_r.ch[1].st
        |=> st_r.log_valid && !st_r.log_ch;
    endproperty
    a_log: assert property (p_log)
        else $error("fault off not logged");
    property p_hot_set;
        st_r.s2[AI_T130] |=> st_r.nvm_block ##1 !nvm_grant;
    endproperty
    a_hot_set: assert property (p_hot_set)
        else $error("memory access not blocked when hot");
    property p_hot_hold;
        st_r.nvm_block && !st_r.s2[AI_T120] |=> st_r.nvm_block;
    endproperty
    a_hot_hold: assert property (p_hot_hold)
        else $error("memory block released early");
    property p_od;
        fault_flag_pin_out == 2'h0 && channel_run_pin_out == 2'h0 &&
        !sync_pin_out && !timebase_pin_out;
    endproperty
    a_od: assert property (p_od)
        else $error("shared line driven high");
    property p_sync;
        $fell(sync_pin_oe_n) |-> s_sync_pulse;
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync low pulse width wrong");
    property p_tb;
        $fell(timebase_pin_oe_n) |-> s_tb_pulse;
    endproperty
    a_tb: assert property (p_tb)
        else $error("timebase low pulse width wrong");
    property p_latch;
        st_r.ch[0].st == CH_LATCH && run[0] && !clr[0]
        |=> st_r.ch[0].st == CH_LATCH;
    endproperty
    a_latch: assert property (p_latch)
        else $error("latched channel restarted by itself");
    property p_bus;
        (avm.read || avm.write) && avm_waitrequest |=> !avm_waitrequest;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus answer late");

endmodule : frm_fault_mgr
`default_nettype wire

// file: hdl/frm_pkg.sv
// Constants and types of the fault response manager
`default_nettype none
package frm_pkg;
    // Timing, clock period 8 ns
    localparam int          CLK_NS       = 8;
    localparam int          SYNC_LOW_NS  = 500;
    localparam int          TB_PER_NS    = 10000;
    localparam int          TB_LOW_NS    = 1000;
    localparam logic [15:0] SYNC_LOW_CYC =
        16'((SYNC_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] TB_PER_CYC   = 16'(TB_PER_NS / CLK_NS);
    localparam logic [15:0] TB_LOW_CYC   =
        16'((TB_LOW_NS + CLK_NS - 1) / CLK_NS);
    // Register byte offsets
    localparam logic [5:0]  A_CTRL    = 6'h00;
    localparam logic [5:0]  A_FLAGSEL = 6'h04;
    localparam logic [5:0]  A_RETRY   = 6'h08;
    localparam logic [5:0]  A_STATUS  = 6'h0c;
    localparam logic [5:0]  A_CLEAR   = 6'h10;
    localparam logic [5:0]  A_PEAK0   = 6'h14;
    localparam logic [5:0]  A_PEAK1   = 6'h18;
    localparam logic [5:0]  A_LOG     = 6'h1c;
    localparam logic [5:0]  A_SYNCPER = 6'h20;
    // Control fields and reset values
    localparam int          CT_LOG     = 0;
    localparam int          CT_SYNC    = 5;
    localparam int          CT_TB      = 6;
    localparam logic [6:0]  CTRL_RST   = 7'h6b;
    localparam logic [11:0] FSEL_RST   = 12'hfff;
    localparam logic [15:0] RETRY_RST  = 16'h000a;
    localparam logic [15:0] SPER_RST   = 16'h00fa;
    // Fault classes: ov, uv, oc, ot, timing, peak oc
    localparam int          FC_OV      = 0;
    // Fault responses
    localparam logic [1:0]  RSP_IGNORE = 2'h0;
    localparam logic [1:0]  RSP_RETRY  = 2'h2;
    // Synchronised input positions
    localparam int          AI_FLAG = 12;
    localparam int          AI_T85  = 16;
    localparam int          AI_T130 = 17;
    localparam int          AI_T120 = 18;
    localparam int          AI_SYNC = 19;
    localparam int          AI_TB   = 20;
    localparam int          NAS     = 21;
    // Synchroniser reset: idle level of every outside input
    localparam logic [NAS-1:0] SYNC_IDLE = 21'h1cf000;

    typedef enum logic [2:0] {
        CH_RUN   = 3'b001,
        CH_LATCH = 3'b010,
        CH_RETRY = 3'b100
    } frm_ch_st_t;

    typedef struct packed {
        frm_ch_st_t  st;
        logic [15:0] rcnt;
        logic [15:0] peak;
        logic        top;
        logic        bot;
        logic        flag_oe_n;
        logic [2:0]  fhist;
        logic        run_oe_n;
    } frm_ch_t;

    typedef struct packed {
        logic           read;
        logic           write;
        logic [5:0]     address;
        logic [31:0]    writedata;
    } frm_avm_t;

    typedef struct packed {
        logic [NAS-1:0] s1;
        logic [NAS-1:0] s2;
        logic           tb_d;
        logic [6:0]     ctrl;
        logic [11:0]    flagsel;
        logic [15:0]    retry;
        logic [15:0]    syncper;
        frm_ch_t [1:0]  ch;
        logic [15:0]    scnt;
        logic           sync_oe_n;
        logic [15:0]    tcnt;
        logic           tb_oe_n;
        logic           nvm_block;
        logic           nvm_grant;
        logic           log_valid;
        logic [6:0]     log_cls;
        logic           log_ch;
        logic [15:0]    log_peak;
        logic           wait_r;
        logic [31:0]    rdata;
        logic           od_zero;
    } frm_state_t;
endpackage : frm_pkg
`default_nettype wire

// file: testbench/frm_fault_mgr_tb.sv
// Self-checking bench of the fault response manager
`timescale 1ns/100ps
`default_nettype none
module frm_fault_mgr_tb
    import frm_pkg::*;
();
    logic        clock, rst, wreq, t85, t130, t120, nreq, ngnt;
    frm_avm_t    avm;
    logic [31:0] rdata, q;
    logic [5:0]  fc0, fc1;
    logic [15:0] meas0;
    logic [1:0]  top, bot, fout, foe, rout, roe, flvl, rlvl, xf, xr;
    logic        sout, soe, slvl, tout, toe, tlvl;
    int          miscompares, comparisons;

    frm_fault_mgr i_dut (.clock(clock), .rst(rst), .avm(avm),
        .avm_readdata(rdata), .avm_waitrequest(wreq),
        .fault_class_ch0(fc0), .fault_class_ch1(fc1),
        .meas_ch0(meas0), .meas_ch1(16'h0010), .pwm_top(2'h3),
        .temp_over_85(t85), .temp_over_130(t130),
        .temp_below_120(t120), .nvm_req(nreq), .nvm_grant(ngnt),
        .top_gate_drive(top), .bottom_gate_drive(bot),
        .fault_flag_pin_in(flvl), .fault_flag_pin_out(fout),
        .fault_flag_pin_oe_n(foe), .channel_run_pin_in(rlvl),
        .channel_run_pin_out(rout), .channel_run_pin_oe_n(roe),
        .sync_pin_in(slvl), .sync_pin_out(sout), .sync_pin_oe_n(soe),
        .timebase_pin_in(tlvl), .timebase_pin_out(tout),
        .timebase_pin_oe_n(toe));
    frm_line_partner i_lines (.dev_flag_oe_n(foe), .dev_run_oe_n(roe),
        .dev_sync_oe_n(soe), .dev_tb_oe_n(toe), .ext_flag_low(xf),
        .ext_run_low(xr), .flag_lvl(flvl), .run_lvl(rlvl),
        .sync_lvl(slvl), .tb_lvl(tlvl));

    // Clock of 8 ns
    always
        #4 clock = ~clock;

    // Verdict and end of run
    task results;
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // A wait that ran out ends the run
    task hang;
        miscompares++;
        results();
    endtask : hang

    // Compare seen against expected
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One bus transfer, held until waitrequest is sampled low at an edge
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock);
        avm <= '{read: !wr, write: wr, address: a, writedata: d};
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        if (wreq !== 1'b0)
            hang();
        q = rdata;
        avm <= '0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    // Read, mask and compare
    task automatic rchk(input string nm, input logic [5:0] a,
                        input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, q & m, e);
    endtask : rchk

    // Let n edges pass, then sample at the falling edge
    task automatic smp(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : smp

    // Wait for the channel 0 run pull-down to reach a level
    task automatic wrun(input logic v, input int b, output int n);
        for (n = 0; n < b && roe[0] !== v; n++) @(negedge clock);
        if (n == b)
            hang();
    endtask : wrun

    function automatic logic ln(input bit s);
        return s ? tlvl : slvl;
    endfunction : ln

    // Low width and period of the sync or timebase line
    task automatic meas(input bit s, output int lo, output int per);
        int n;
        for (n = 0; n < 3000 && ln(s) !== 1'b0; n++) @(negedge clock);
        for (n = 0; n < 3000 && ln(s) !== 1'b1; n++) @(negedge clock);
        for (n = 0; n < 3000 && ln(s) !== 1'b0; n++) @(negedge clock);
        for (lo = 0; lo < 3000 && ln(s) === 1'b0; lo++) @(negedge clock);
        for (per = lo; per < 3000 && ln(s) === 1'b1; per++) @(negedge clock);
        if (per >= 3000)
            hang();
    endtask : meas

    // Reset values, an unmapped place and idle status
    task automatic t_regs;
        rchk("ctrl", A_CTRL, '1, 32'(CTRL_RST));
        rchk("flagsel", A_FLAGSEL, '1, 32'(FSEL_RST));
        rchk("retry", A_RETRY, '1, 32'(RETRY_RST));
        rchk("syncper", A_SYNCPER, '1, 32'(SPER_RST));
        rchk("unmapped", 6'h24, '1, 32'h0);
        rchk("status", A_STATUS, 32'h13f, 32'h30);
    endtask : t_regs

    // Peaks, overvoltage latch-off, log capture, clear
    task automatic t_ov;
        @(posedge clock);
        meas0 <= 16'h0100;
        wr(A_CLEAR, 32'h8);
        meas0 <= 16'h0456;
        smp(3);
        @(posedge clock);
        meas0 <= 16'h0200;
        rchk("peak", A_PEAK0, '1, 32'h0456);
        @(posedge clock);
        fc0 <= 6'h01;
        smp(2);
        chk("top early", 32'(top[0]), 32'h1);
        smp(1);
        chk("top ov", 32'(top[0]), 32'h0);
        chk("bottom ov", 32'(bot[0]), 32'h1);
        chk("flag ov", 32'(foe[0]), 32'h0);
        @(posedge clock);
        fc0 <= 6'h00;
        smp(40);
        rchk("latched", A_STATUS, 32'h113, 32'h101);
        rchk("log", A_LOG, 32'hffff00ff, 32'h04560001);
        wr(A_CLEAR, 32'h1);
        smp(4);
        rchk("cleared", A_STATUS, 32'h13, 32'h10);
        chk("top run", 32'(top[0]), 32'h1);
        wr(A_CLEAR, 32'h8);
        rchk("peak new", A_PEAK0, '1, 32'h0200);
    endtask : t_ov

    // Foreign low on flag line, exit by a run-line cycle
    task automatic t_ext;
        @(posedge clock);
        xf <= 2'h1;
        smp(6);
        chk("top ext", 32'(top[0]), 32'h0);
        @(posedge clock);
        xf <= 2'h0;
        rchk("ext latch", A_STATUS, 32'h3, 32'h1);
        @(posedge clock);
        xr <= 2'h1;
        smp(6);
        @(posedge clock);
        xr <= 2'h0;
        smp(6);
        rchk("run cycle", A_STATUS, 32'h13, 32'h10);
    endtask : t_ext

    // Each class alone on flag pin 1, response ignore
    task automatic t_sel;
        int i;
        wr(A_CTRL, 32'h61);
        for (i = 0; i < 6; i++)
        begin
            wr(A_FLAGSEL, 32'h1 << (6 + i));
            fc1 <= 6'h1 << ((i + 1) % 6);
            smp(4);
            chk("flag other", 32'(foe[1]), 32'h1);
            @(posedge clock);
            fc1 <= 6'h1 << i;
            smp(4);
            chk("flag sel", 32'(foe[1]), 32'h0);
            chk("top ignore", 32'(top[1]), 32'(i != 0));
            @(posedge clock);
            fc1 <= 6'h00;
            smp(4);
        end
        wr(A_FLAGSEL, 32'(FSEL_RST));
        wr(A_CTRL, 32'(CTRL_RST));
    endtask : t_sel

    // Retry with log off: wait, restart, retry again while faulty
    task automatic t_retry;
        int n;
        wr(A_CLEAR, 32'h4);
        wr(A_CTRL, 32'h6c);
        wr(A_RETRY, 32'h2);
        fc0 <= 6'h04;
        wrun(1'b0, 10, n);
        chk("top retry", 32'(top[0]), 32'h0);
        wrun(1'b1, 2700, n);
        chk("retry wait", 32'(n > 1240 && n < 2520), 32'h1);
        wrun(1'b0, 10, n);
        @(posedge clock);
        fc0 <= 6'h00;
        wrun(1'b1, 2700, n);
        smp(3);
        chk("top restart", 32'(top[0]), 32'h1);
        rchk("no log", A_STATUS, 32'h13c, 32'h30);
        wr(A_CTRL, 32'(CTRL_RST));
    endtask : t_retry

    // Memory gate and its 130/120 hysteresis
    task automatic t_nvm;
        @(posedge clock);
        t85 <= 1'b1;
        smp(3);
        rchk("hot", A_STATUS, 32'h80, 32'h80);
        @(posedge clock);
        t85 <= 1'b0;
        nreq <= 1'b1;
        smp(3);
        chk("grant cool", 32'(ngnt), 32'h1);
        @(posedge clock);
        t130 <= 1'b1;
        t120 <= 1'b0;
        smp(4);
        chk("grant hot", 32'(ngnt), 32'h0);
        @(posedge clock);
        t130 <= 1'b0;
        smp(4);
        chk("grant band", 32'(ngnt), 32'h0);
        @(posedge clock);
        t120 <= 1'b1;
        smp(4);
        chk("grant back", 32'(ngnt), 32'h1);
        @(posedge clock);
        nreq <= 1'b0;
        smp(1);
        chk("grant idle", 32'(ngnt), 32'h0);
    endtask : t_nvm

    // Sync and timebase pulse widths and periods
    task automatic t_lines;
        int lo;
        int per;
        meas(1'b0, lo, per);
        chk("sync low", lo, 32'(SYNC_LOW_CYC));
        chk("sync period", per, 32'(SPER_RST));
        wr(A_SYNCPER, 32'h64);
        meas(1'b0, lo, per);
        chk("sync low 2", lo, 32'(SYNC_LOW_CYC));
        chk("sync period 2", per, 32'h64);
        meas(1'b1, lo, per);
        chk("tb low", lo, 32'(TB_LOW_CYC));
        chk("tb period", per, 32'(TB_PER_CYC));
        chk("od outs", {fout, rout, sout, tout}, 32'h0);
    endtask : t_lines

    // Main sequence
    initial
    begin
        {clock, rst, t85, t130, t120, nreq} = 6'h12;
        {avm, fc0, fc1, meas0, xf, xr} = '0;
        miscompares = 0;
        comparisons = 0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_ov();
        t_ext();
        t_sel();
        t_retry();
        t_nvm();
        t_lines();
        results();
    end

    // Cuts a hang short
    initial
    begin
        repeat (100000) @(posedge clock);
        hang();
    end
endmodule : frm_fault_mgr_tb
`default_nettype wire

// file: testbench/frm_line_partner.sv
// Other parties on the shared open-drain lines
`timescale 1ns/100ps
`default_nettype none
module frm_line_partner
(
    // Device pull-downs, low while pulling
    input  wire logic [1:0] dev_flag_oe_n,
    input  wire logic [1:0] dev_run_oe_n,
    input  wire logic       dev_sync_oe_n,
    input  wire logic       dev_tb_oe_n,
    // Outside pull-downs commanded by the bench
    input  wire logic [1:0] ext_flag_low,
    input  wire logic [1:0] ext_run_low,
    // Resolved levels
    output var  logic [1:0] flag_lvl,
    output var  logic [1:0] run_lvl,
    output var  logic       sync_lvl,
    output var  logic       tb_lvl
);
    // Wired-AND with pull-ups: any party pulling low wins
    assign flag_lvl = dev_flag_oe_n & ~ext_flag_low;
    assign run_lvl  = dev_run_oe_n & ~ext_run_low;
    assign sync_lvl = dev_sync_oe_n;
    assign tb_lvl   = dev_tb_oe_n;
endmodule : frm_line_partner
`default_nettype wire
